// ### include/dld_consts.svh
// Constants for the dual latch and segment decoder block
`ifndef DLD_CONSTS_SVH
`define DLD_CONSTS_SVH

`define DLD_CODE_W 14
`define DLD_CHANNELS 2
`define DLD_UPPER_SRC 31
`define DLD_MID_SRC 15
`define DLD_LOW_BITS 5
`define DLD_SW_W 51
`define DLD_SW_MID_LSB 5
`define DLD_SW_UP_LSB 20
`define DLD_CODE_UP_LSB 9
`define DLD_CODE_MID_LSB 5
`define DLD_RESET_CODE 14'h0000
`define DLD_FIFO_DEPTH 16
`define DLD_FIFO_W 15
`define DLD_SEL_BIT 14
`define DLD_MAX_RATE_MSPS 125
`define DLD_REF_CLK_MHZ 40

`define DLD_OFF_CTRL 4'h0
`define DLD_OFF_STATUS 4'h4
`define DLD_OFF_CODE1 4'h8
`define DLD_OFF_CODE2 4'hC

`define DLD_CTRL_SLEEP_BIT 0
`define DLD_CTRL_FLUSH_BIT 1
`define DLD_STAT_DUAL_BIT 0
`define DLD_STAT_GAIN_BIT 1
`define DLD_STAT_SLEEP_BIT 2
`define DLD_STAT_PEND_LSB 3
`define DLD_STAT_LEVEL_LSB 8
`define DLD_WB_ZERO 32'h0000_0000

`endif

// ### include/dld_pkg.sv
// Types shared by the dual latch and segment decoder block
`default_nettype none
`include "dld_consts.svh"

package dld_pkg;
  typedef logic [`DLD_CODE_W-1:0] dld_code_t;
  typedef logic [`DLD_SW_W-1:0] dld_switch_t;
  typedef enum logic {DLD_MODE_INTERLEAVED, DLD_MODE_DUAL} dld_mode_t;
endpackage

`default_nettype wire

// ### include/dld_stream_if.sv
// Valid/ready word stream between the port logic and the FIFO
`timescale 1ns/100ps
`default_nettype none

interface dld_stream_if #(parameter int W = 15);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ### design/dld_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module dld_fifo #(
  parameter int W = 15,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic flush,
  dld_stream_if.snk in_s,
  dld_stream_if.src out_s,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign level = wr_q - rd_q;
  assign in_s.ready = level != (AW+1)'(DEPTH);
  assign out_s.valid = level != '0;
  assign out_s.data = mem_q[rd_q[AW-1:0]];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  // Storage needs no reset; level guards every read
  always_ff @(posedge ref_clk)
  begin
    if (push && !flush)
      mem_q[wr_q[AW-1:0]] <= in_s.data;
  end
endmodule

`default_nettype wire

// ### design/dld_latch_decoder.sv
// Dual converter input latches, interleave demux and segment decoders
`timescale 1ns/100ps
`default_nettype none
`include "dld_consts.svh"

module dld_latch_decoder
  import dld_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [`DLD_CODE_W-1:0] first_data_port,
  input wire logic [`DLD_CODE_W-1:0] second_data_port,
  input wire logic first_write_strobe,
  input wire logic first_update_clock,
  input wire logic second_update_clock,
  input wire logic second_write_strobe,
  input wire logic port_mode_select,
  input wire logic power_down,
  input wire logic gain_mode_select,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic interleaved_ready,
  output logic powered_down,
  output logic shared_gain_mode,
  output logic [`DLD_SW_W-1:0] first_true_switch,
  output logic [`DLD_SW_W-1:0] first_comp_switch,
  output logic [`DLD_SW_W-1:0] second_true_switch,
  output logic [`DLD_SW_W-1:0] second_comp_switch
);
  localparam int LW = $clog2(`DLD_FIFO_DEPTH) + 1;

  // Segment decode of one straight binary code
  function automatic dld_switch_t dld_decode(input dld_code_t c);
    dld_switch_t s;
    s = '0;
    for (int i = 0; i < `DLD_UPPER_SRC; i++)
      s[`DLD_SW_UP_LSB + i] = i < int'(c[`DLD_CODE_W-1:`DLD_CODE_UP_LSB]);
    for (int i = 0; i < `DLD_MID_SRC; i++)
      s[`DLD_SW_MID_LSB + i] = i < int'(c[`DLD_CODE_UP_LSB-1:`DLD_CODE_MID_LSB]);
    s[`DLD_LOW_BITS-1:0] = c[`DLD_LOW_BITS-1:0];
    return s;
  endfunction

  logic [3:0] pins;
  logic [3:0] pins_q;
  logic [3:0] rise;
  dld_mode_t mode_q;
  logic gain_q;
  logic sleep_q;
  logic ctrl_sleep_q;
  logic ctrl_flush_q;
  logic asleep;
  logic dual;
  logic ileave;
  logic iq_reset;
  logic iq_sel;
  logic iq_load;
  logic both_pending;
  logic fifo_flush;
  logic [LW-1:0] fifo_level;
  logic wb_req;
  logic ack_q;
  logic ctrl_wr;
  logic [31:0] rdat_q;
  logic [31:0] rd_mux;
  dld_code_t in_latch_q [`DLD_CHANNELS];
  dld_code_t stage_q [`DLD_CHANNELS];
  dld_code_t code_q [`DLD_CHANNELS];
  logic pending_q [`DLD_CHANNELS];
  dld_switch_t true_q [`DLD_CHANNELS];
  dld_switch_t comp_q [`DLD_CHANNELS];

  dld_stream_if #(.W(`DLD_FIFO_W)) push_s ();
  dld_stream_if #(.W(`DLD_FIFO_W)) pop_s ();

  // Control pins in pin order; their meaning depends on mode
  assign pins = {second_write_strobe, second_update_clock, first_update_clock,
                 first_write_strobe};
  assign rise = pins & ~pins_q;
  assign dual = mode_q == DLD_MODE_DUAL;
  assign ileave = mode_q == DLD_MODE_INTERLEAVED;
  assign iq_reset = ileave & pins[2];
  assign iq_sel = pins[3];
  assign asleep = sleep_q | ctrl_sleep_q;
  assign both_pending = pending_q[0] & pending_q[1];
  assign iq_load = ileave & rise[1] & both_pending & ~iq_reset;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pins_q <= 4'h0;
    else
      pins_q <= pins;
  end

  // Static pins are sampled each cycle, not latched
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_q <= DLD_MODE_DUAL;
      gain_q <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      mode_q <= dld_mode_t'(port_mode_select);
      gain_q <= gain_mode_select;
      sleep_q <= power_down;
    end
  end

  assign shared_gain_mode = gain_q;
  assign powered_down = asleep;

  // Interleaved words queue with their channel select bit
  assign push_s.valid = ileave & rise[0] & ~asleep & ~iq_reset;
  assign push_s.data = {iq_sel, first_data_port};
  assign interleaved_ready = ileave & push_s.ready;
  assign pop_s.ready = ileave & ~iq_reset & ~pending_q[pop_s.data[`DLD_SEL_BIT]];
  // Flushing in dual mode keeps stale words from leaking into a later switch
  assign fifo_flush = dual | iq_reset | ctrl_flush_q;

  dld_fifo #(.W(`DLD_FIFO_W), .DEPTH(`DLD_FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .flush(fifo_flush),
    .in_s(push_s),
    .out_s(pop_s),
    .level(fifo_level)
  );

  for (genvar ch = 0; ch < `DLD_CHANNELS; ch++)
  begin : g_chan
    logic wr_rise;
    logic upd_rise;
    logic take;
    dld_code_t port_data;

    assign wr_rise = (ch == 0) ? rise[0] : rise[3];
    assign upd_rise = (ch == 0) ? rise[1] : rise[2];
    assign port_data = (ch == 0) ? first_data_port : second_data_port;
    assign take = pop_s.valid & pop_s.ready & (pop_s.data[`DLD_SEL_BIT] == 1'(ch));

    // Input latch of the double buffer
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
        in_latch_q[ch] <= `DLD_RESET_CODE;
      else if (dual && wr_rise)
        in_latch_q[ch] <= port_data;
    end

    // Demux staging; a newly taken word wins over a clear
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        stage_q[ch] <= `DLD_RESET_CODE;
        pending_q[ch] <= 1'b0;
      end
      else
      begin
        if (take)
          stage_q[ch] <= pop_s.data[`DLD_CODE_W-1:0];
        pending_q[ch] <= take | (pending_q[ch] & ~(iq_load | iq_reset | dual));
      end
    end

    // Converter latch; held while asleep so output stays put
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
        code_q[ch] <= `DLD_RESET_CODE;
      else if (!asleep)
      begin
        if (dual && upd_rise)
          code_q[ch] <= in_latch_q[ch];
        else if (iq_load)
          code_q[ch] <= stage_q[ch];
      end
    end

    // Complementary pair from one decode so neither output is ever skipped
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        true_q[ch] <= '0;
        comp_q[ch] <= '1;
      end
      else
      begin
        true_q[ch] <= dld_decode(code_q[ch]);
        comp_q[ch] <= ~dld_decode(code_q[ch]);
      end
    end
  end

  assign first_true_switch = true_q[0];
  assign first_comp_switch = comp_q[0];
  assign second_true_switch = true_q[1];
  assign second_comp_switch = comp_q[1];

  // Wishbone slave: one wait state, unmapped offsets read zero
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign ctrl_wr = wb_req & ack_q & wb_we_i & (wb_adr_i == `DLD_OFF_CTRL) & wb_sel_i[0];

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ack_q <= 1'b0;
    else
      ack_q <= wb_req & ~ack_q;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_sleep_q <= 1'b0;
      ctrl_flush_q <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_sleep_q <= wb_dat_i[`DLD_CTRL_SLEEP_BIT];
      ctrl_flush_q <= ctrl_wr & wb_dat_i[`DLD_CTRL_FLUSH_BIT];
    end
  end

  always_comb
  begin
    rd_mux = `DLD_WB_ZERO;
    unique case (wb_adr_i)
      `DLD_OFF_CTRL:
        rd_mux[`DLD_CTRL_SLEEP_BIT] = ctrl_sleep_q;
      `DLD_OFF_STATUS:
      begin
        rd_mux[`DLD_STAT_DUAL_BIT] = dual;
        rd_mux[`DLD_STAT_GAIN_BIT] = gain_q;
        rd_mux[`DLD_STAT_SLEEP_BIT] = asleep;
        rd_mux[`DLD_STAT_PEND_LSB] = pending_q[0];
        rd_mux[`DLD_STAT_PEND_LSB + 1] = pending_q[1];
        rd_mux[`DLD_STAT_LEVEL_LSB +: LW] = fifo_level;
      end
      `DLD_OFF_CODE1:
        rd_mux[`DLD_CODE_W-1:0] = code_q[0];
      `DLD_OFF_CODE2:
        rd_mux[`DLD_CODE_W-1:0] = code_q[1];
      default:
        rd_mux = `DLD_WB_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rdat_q <= `DLD_WB_ZERO;
    else if (wb_req && !ack_q)
      rdat_q <= rd_mux;
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
endmodule

`default_nettype wire

// ### verification/dld_sva.sv
// Port checker for the latch and decode block
`timescale 1ns/100ps
`default_nettype none

module dld_sva (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic gain_mode_select,
  input wire logic shared_gain_mode,
  input wire logic power_down,
  input wire logic powered_down,
  input wire logic port_mode_select,
  input wire logic interleaved_ready,
  input wire logic [50:0] first_true_switch,
  input wire logic [50:0] first_comp_switch,
  input wire logic [50:0] second_true_switch,
  input wire logic [50:0] second_comp_switch
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Two samples needed: a load taken at the first edge still shows
  sequence asleep_two;
    powered_down ##1 powered_down;
  endsequence
  chk_comp_inverse: assert property (
    first_comp_switch == ~first_true_switch && second_comp_switch == ~second_true_switch)
    else $error("comp not inverse");
  chk_therm_upper: assert property (
    (first_true_switch[50:20] & (first_true_switch[50:20] + 31'h1)) == 31'h0)
    else $error("upper not thermometer");
  chk_therm_mid: assert property (
    (second_true_switch[19:5] & (second_true_switch[19:5] + 15'h1)) == 15'h0)
    else $error("middle not thermometer");
  chk_ack_pulse: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not single pulse");
  chk_gain_follow: assert property (
    $past(resetn) |-> shared_gain_mode == $past(gain_mode_select))
    else $error("gain mode lag");
  chk_sleep_pin: assert property (power_down |=> powered_down)
    else $error("sleep pin ignored");
  chk_sleep_hold: assert property (
    asleep_two |=> $stable(first_true_switch) && $stable(second_true_switch))
    else $error("switches moved asleep");
  chk_dual_idle: assert property (port_mode_select [*3] |-> !interleaved_ready)
    else $error("ready in dual mode");
endmodule

bind dld_latch_decoder dld_sva u_dld_sva (
  .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .gain_mode_select(gain_mode_select),
  .shared_gain_mode(shared_gain_mode), .power_down(power_down),
  .powered_down(powered_down), .port_mode_select(port_mode_select),
  .interleaved_ready(interleaved_ready), .first_true_switch(first_true_switch),
  .first_comp_switch(first_comp_switch), .second_true_switch(second_true_switch),
  .second_comp_switch(second_comp_switch)
);

`default_nettype wire

// ### verification/dld_source_model.sv
// Data source model driving the converter data and control pins
`timescale 1ns/100ps
`default_nettype none

module dld_source_model (
  input wire logic ref_clk,
  output logic [13:0] first_data_port,
  output logic [13:0] second_data_port,
  output logic first_write_strobe,
  output logic first_update_clock,
  output logic second_update_clock,
  output logic second_write_strobe
);
  initial
  begin
    {first_data_port, second_data_port} = 28'h000_0000;
    {first_write_strobe, first_update_clock, second_update_clock, second_write_strobe} = 4'h0;
  end
  // Strobe, then clock; released data shows its inverse
  task automatic dual_write(input logic port, input logic [13:0] code);
    @(posedge ref_clk);
    if (port)
      second_data_port <= code;
    else
      first_data_port <= code;
    second_write_strobe <= port;
    first_write_strobe <= !port;
    @(posedge ref_clk);
    {first_write_strobe, second_write_strobe} <= 2'h0;
    {first_data_port, second_data_port} <= ~{first_data_port, second_data_port};
    second_update_clock <= port;
    first_update_clock <= !port;
    @(posedge ref_clk);
    {first_update_clock, second_update_clock} <= 2'h0;
  endtask
  task automatic iq_write(input logic sel, input logic [13:0] code);
    @(posedge ref_clk);
    first_data_port <= code;
    second_write_strobe <= sel;
    first_write_strobe <= 1'b1;
    @(posedge ref_clk);
    first_write_strobe <= 1'b0;
    first_data_port <= ~code;
    second_write_strobe <= ~sel;
  endtask
  // One pulse on the interleaved clock or on the phase reset
  task automatic iq_pulse(input logic phase_reset);
    @(posedge ref_clk);
    first_update_clock <= !phase_reset;
    second_update_clock <= phase_reset;
    @(posedge ref_clk);
    {first_update_clock, second_update_clock} <= 2'h0;
  endtask
endmodule

`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the latch and decode block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import dld_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic mode = 1'b1;
  logic sleep = 1'b0;
  logic gain = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, rd;
  logic ack, irdy, pdn, sgain, w1, k1, k2, w2, p;
  dld_code_t d1, d2, ea, eb, a;
  dld_switch_t t1, p1, t2, p2;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 49;
  int cycles = 0;

  dld_source_model src (.ref_clk(ref_clk), .first_data_port(d1), .second_data_port(d2),
    .first_write_strobe(w1), .first_update_clock(k1), .second_update_clock(k2),
    .second_write_strobe(w2));
  dld_latch_decoder DUT (.ref_clk(ref_clk), .resetn(resetn), .first_data_port(d1),
    .second_data_port(d2), .first_write_strobe(w1), .first_update_clock(k1),
    .second_update_clock(k2), .second_write_strobe(w2), .port_mode_select(mode),
    .power_down(sleep), .gain_mode_select(gain), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .interleaved_ready(irdy), .powered_down(pdn), .shared_gain_mode(sgain),
    .first_true_switch(t1), .first_comp_switch(p1), .second_true_switch(t2),
    .second_comp_switch(p2));

  always #12.5 ref_clk = ~ref_clk;

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Run is well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic dld_switch_t exp_sw(input dld_code_t c);
    dld_switch_t r;
    r = '0;
    r[4:0] = c[4:0];
    for (int k = 0; k < 15; k++)
      r[5 + k] = k < c[8:5];
    for (int k = 0; k < 31; k++)
      r[20 + k] = k < c[13:9];
    return r;
  endfunction

  // Single classic cycle; stb follows cyc
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dt);
    int i;
    @(posedge ref_clk);
    {cyc, we, adr, wdat} <= {1'b1, w, ad, dt};
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    rd = rdat;
    if (i == 20)
      n_mismatch++;
    cyc <= 1'b0;
    #1;
  endtask

  task automatic chk_sw();
    @(posedge ref_clk);
    #1;
    check(t1, exp_sw(ea));
    check(p1, dld_switch_t'(~exp_sw(ea)));
    check(t2, exp_sw(eb));
    check(p2, dld_switch_t'(~exp_sw(eb)));
  endtask

  initial
  begin
    ea = '0;
    eb = '0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk_sw();
    for (int i = 0; i < 24; i++)
    begin
      a = (i < 4) ? {14{i[1]}} : dld_code_t'($random(seed));
      p = i[0] ^ 1'($random(seed));
      src.dual_write(p, a);
      if (p)
        eb = a;
      else
        ea = a;
      chk_sw();
    end
    wb(0, 4'h8, 0);
    check(rd, ea);
    wb(1, 4'h8, 32'h0000_1234);
    wb(0, 4'h8, 0);
    check(rd, ea);
    wb(1, 4'h2, 32'hFFFF_FFFF);
    check(rd, 0);
    $display("dual port tests done");
    sleep <= 1'b1;
    src.dual_write(0, ~ea);
    chk_sw();
    check(pdn, 1);
    sleep <= 1'b0;
    wb(1, 4'h0, 32'h0000_0001);
    check(pdn, 1);
    wb(0, 4'h4, 0);
    check(rd[2], 1);
    wb(1, 4'h0, 32'h0000_0000);
    check(pdn, 0);
    for (int g = 0; g < 2; g++)
    begin
      gain <= g[0];
      wb(0, 4'h4, 0);
      check(sgain, g[0]);
      check(rd[1], g[0]);
    end
    $display("sleep and gain tests done");
    mode <= 1'b0;
    wb(0, 4'h4, 0);
    check(rd[0], 0);
    eb = dld_code_t'($random(seed));
    ea = dld_code_t'($random(seed));
    src.iq_write(1, eb);
    src.iq_write(0, ea);
    repeat (2) @(posedge ref_clk);
    src.iq_pulse(0);
    chk_sw();
    for (int i = 0; i < 18; i++)
      src.iq_write(0, dld_code_t'($random(seed)));
    #1;
    check(irdy, 0);
    wb(0, 4'h4, 0);
    check(rd[12:8], 5'h10);
    check(rd[3], 1);
    src.iq_pulse(1);
    wb(0, 4'h4, 0);
    check({irdy, rd[12:8], rd[3]}, 7'h40);
    chk_sw();
    // Second word for a staged channel must wait in the queue
    src.iq_write(1, ~eb);
    src.iq_write(1, eb);
    wb(0, 4'h4, 0);
    check(rd[12:3], 10'h022);
    // Soft flush empties the queue but keeps the staged word
    wb(1, 4'h0, 32'h0000_0002);
    wb(0, 4'h4, 0);
    check(rd[12:3], 10'h002);
    // Clock with one channel missing must not load either converter
    src.iq_pulse(0);
    chk_sw();
    $display("interleaved tests done");
    finish_test();
  end
endmodule

`default_nettype wire
